//--- core/stepper_params.svh
// constants for the serial stepper command block
`ifndef STEPPER_PARAMS_SVH
`define STEPPER_PARAMS_SVH

// serial word framing
`define WORD_BITS 6'h20
`define BIT_COUNT_RST 6'h00
`define BIT_COUNT_ONE 6'h01
`define CFG_SENSE_BIT 12
`define CFG_GAIN_BIT 13
`define CFG_USED_MASK 32'h0000_3000
`define MOTOR_ZERO_MASK 32'h0000_0023
`define WORD_RST 32'h0000_0000

// timing
`define CLK_MHZ 125
`define OPEN_LOAD_TIME_US 200
`define OPEN_WAIT_W 16
`define OPEN_WAIT_RST 16'h0000
`define OPEN_WAIT_ONE 16'h0001

// applied-setting reset values
`define RST_CURRENT 10'h000
`define RST_TORQUE 3'h0
`define RST_DECAY 2'h0
`define RST_PCT 7'h64
`define STEP_W 8
`define STEP_RST 8'h00
`define STEP_ONE 8'h01

// torque code to percent
`define TQ_PCT_0 7'h64
`define TQ_PCT_1 7'h55
`define TQ_PCT_2 7'h46
`define TQ_PCT_3 7'h3c
`define TQ_PCT_4 7'h32
`define TQ_PCT_5 7'h28
`define TQ_PCT_6 7'h19
`define TQ_PCT_7 7'h0a
`define PCT_DIVISOR 17'h00064

// synchronised pin indices
`define NUM_IN 13
`define IN_SCLK 0
`define IN_SDATA 1
`define IN_LATCH 2
`define IN_BANK 3
`define IN_IFSEL 4
`define IN_STBY_N 5
`define IN_SUPPLY 6
`define IN_THERMAL 7
`define IN_OVERCUR 8
`define IN_CHARGE_A 9
`define IN_CHARGE_B 10
`define IN_THRESH_A 11
`define IN_THRESH_B 12
`define IN_RST 13'h0000

`endif

//--- core/stepper_pkg.sv
// types shared by the serial stepper command block
package stepper_pkg;
  typedef logic [9:0] current_code_t;
  typedef logic [6:0] pct_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CONFIG = 2'b01,
    ST_DRIVE = 2'b10
  } drive_state_e;

  // motor-control word, most significant field first
  typedef struct packed {
    current_code_t current_b;
    logic polarity_b;
    logic [1:0] decay_b;
    current_code_t current_a;
    logic polarity_a;
    logic [1:0] decay_a;
    logic zero_d5;
    logic [2:0] torque_code;
    logic [1:0] zero_d1_d0;
  } motor_word_s;
endpackage

//--- core/open_load_if.sv
// carrier between the top and one open-load detector
`timescale 1ns/10ps
interface open_load_if;
  logic charge;
  logic threshold;
  logic open_load;
  modport det (input charge, input threshold, output open_load);
  modport top (output charge, output threshold, input open_load);
endinterface

//--- core/open_load_detect.sv
// open-load detector for one bridge channel
`timescale 1ns/10ps
`include "stepper_params.svh"
module open_load_detect
  import stepper_pkg::*;
#(
  parameter int unsigned WAIT_CYCLES = `OPEN_LOAD_TIME_US * `CLK_MHZ
) (
  input wire logic clk,
  input wire logic rst,
  open_load_if.det ch
);
  localparam logic [`OPEN_WAIT_W-1:0] LIMIT = WAIT_CYCLES[`OPEN_WAIT_W-1:0];

  logic charge_prev_ff;
  logic [`OPEN_WAIT_W-1:0] wait_ff;
  logic seen_ff;
  logic flag_ff;
  logic charge_rise;
  logic charge_fall;

  assign charge_rise = ch.charge & ~charge_prev_ff;
  assign charge_fall = ~ch.charge & charge_prev_ff;
  assign ch.open_load = flag_ff;

  // edge memory of the charge phase
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      charge_prev_ff <= 1'b0;
    end else begin
      charge_prev_ff <= ch.charge;
    end
  end

  // time since charge start, stops once the threshold is seen
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wait_ff <= `OPEN_WAIT_RST;
    end else if (charge_rise) begin
      wait_ff <= `OPEN_WAIT_RST;
    end else if (ch.charge && !seen_ff && wait_ff != LIMIT) begin
      wait_ff <= wait_ff + `OPEN_WAIT_ONE;
    end
  end

  // threshold seen during the current charge phase
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      seen_ff <= 1'b0;
    end else if (charge_rise) begin
      seen_ff <= ch.threshold;
    end else if (ch.charge && ch.threshold) begin
      seen_ff <= 1'b1;
    end
  end

  // flag on timeout, release at charge end after threshold
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flag_ff <= 1'b0;
    end else if (ch.charge && !seen_ff && !ch.threshold && wait_ff == LIMIT) begin
      flag_ff <= 1'b1;
    end else if (charge_fall && seen_ff) begin
      flag_ff <= 1'b0;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  a_open_set_time: assert property (@(posedge clk) disable iff (rst)
    $rose(flag_ff) |-> $past(wait_ff) == LIMIT && !$past(seen_ff))
    else $error("open load flagged before the wait elapsed");
  a_open_release: assert property (@(posedge clk) disable iff (rst)
    $fell(flag_ff) |-> $past(charge_fall) && $past(seen_ff))
    else $error("open load released outside a charge end");
endmodule // open_load_detect

//--- core/stepper_serial_top.sv
// serial command interface and fault flags of a two-channel stepper driver
// Operation
// - with interface select high, 32-bit serial words configure and drive the motor.
// - bank-select low means configuration word, high means motor-control word.
// - serial currents wait pending and reach the bridge only on latch.
// - configuration D12 picks sense method, D13 reference gain; other bits zero.
// - motor word fields: torque, decay, polarity and current code per channel.
// - every accepted motor command advances the step count by exactly one; refused words leave it.
// - polarity 0 drives current minus, polarity 1 drives current plus.
// - current limit scales as code over 1023 times torque percent.
// - torque code maps 100, 85, 70, 60, 50, 40, 25, 10 percent.
// - both fault flags are open drain, floating normal, pulled low on fault.
// - flag1 low is open load, flag0 low overcurrent, both thermal.
// - thermal and overcurrent latch; open load clears on its own.
// - latched faults release on motor supply return or standby.
// - open load flagged when threshold is missed 200 us after charge start.
// - open load never stops the outputs or enters standby.
// - open load releases at charge end after the threshold is reached.
// - standby low stops oscillator and output stage; high is normal.
// - sense select 0 is internal detection, 1 external sense resistor.
// - gain select 0 is one fifth, 1 is one tenth.
// - decay code picks 37.5 percent, 50 percent, fast only or adaptive.
`timescale 1ns/10ps
`include "stepper_params.svh"
module stepper_serial_top
  import stepper_pkg::*;
#(
  parameter int unsigned OPEN_WAIT_CYCLES = `OPEN_LOAD_TIME_US * `CLK_MHZ
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic if_sel,
  input wire logic bank_sel,
  input wire logic serial_clk,
  input wire logic serial_data,
  input wire logic latch,
  input wire logic standby_n,
  input wire logic motor_supply,
  input wire logic thermal_shutdown_fault,
  input wire logic overcurrent_fault,
  input wire logic charge_phase_a,
  input wire logic charge_phase_b,
  input wire logic current_threshold_reached_a,
  input wire logic current_threshold_reached_b,
  output logic sense_method_select,
  output logic gain_select,
  output logic [6:0] torque_percent,
  output logic [1:0] decay_a,
  output logic polarity_a,
  output logic [9:0] current_code_a,
  output logic [9:0] current_limit_a,
  output logic [1:0] decay_b,
  output logic polarity_b,
  output logic [9:0] current_code_b,
  output logic [9:0] current_limit_b,
  output logic bridge_enable,
  output logic osc_enable,
  output logic [`STEP_W-1:0] step_count,
  output logic fault_flag0_o,
  output logic fault_flag0_oe,
  output logic fault_flag1_o,
  output logic fault_flag1_oe
);

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic [`NUM_IN-1:0] pins;
  logic [`NUM_IN-1:0] s1_ff;
  logic [`NUM_IN-1:0] s2_ff;
  logic [`NUM_IN-1:0] s3_ff;
  logic [`NUM_IN-1:0] flt_ff;
  logic [`NUM_IN-1:0] prev_ff;

  assign pins = {current_threshold_reached_b, current_threshold_reached_a, charge_phase_b,
                 charge_phase_a, overcurrent_fault, thermal_shutdown_fault, motor_supply,
                 standby_n, if_sel, bank_sel, latch, serial_data, serial_clk};

  // three-stage capture, filtered level moves when stages two and three agree
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_ff <= `IN_RST;
      s2_ff <= `IN_RST;
      s3_ff <= `IN_RST;
      flt_ff <= `IN_RST;
      prev_ff <= `IN_RST;
    end else begin
      s1_ff <= pins;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      flt_ff <= (~(s2_ff ^ s3_ff) & s2_ff) | ((s2_ff ^ s3_ff) & flt_ff);
      prev_ff <= flt_ff;
    end
  end

  logic sclk_rise;
  logic latch_rise;
  logic supply_rise;
  logic serial_on;
  logic standby;
  logic bank_high;

  assign sclk_rise = flt_ff[`IN_SCLK] & ~prev_ff[`IN_SCLK];
  assign latch_rise = flt_ff[`IN_LATCH] & ~prev_ff[`IN_LATCH];
  assign supply_rise = flt_ff[`IN_SUPPLY] & ~prev_ff[`IN_SUPPLY];
  assign serial_on = flt_ff[`IN_IFSEL];
  assign standby = ~flt_ff[`IN_STBY_N];
  assign bank_high = flt_ff[`IN_BANK];

  // ************************************************************
  // serial shifter
  // ************************************************************
  logic [31:0] shift_ff;
  logic [5:0] count_ff;
  logic word_full;

  assign word_full = (count_ff == `WORD_BITS);

  // shift D0 first; count saturates at a full word
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      shift_ff <= `WORD_RST;
      count_ff <= `BIT_COUNT_RST;
    end else if (standby || !serial_on || latch_rise) begin
      count_ff <= `BIT_COUNT_RST;
    end else if (sclk_rise) begin
      shift_ff <= {flt_ff[`IN_SDATA], shift_ff[31:1]};
      if (!word_full) begin
        count_ff <= count_ff + `BIT_COUNT_ONE;
      end
    end
  end

  logic word_take;
  logic cfg_take;
  logic mot_take;

  // a full word taken on latch, routed by bank level, reserved bits zero
  assign word_take = latch_rise && word_full && serial_on && !standby;
  assign cfg_take = word_take && !bank_high && ((shift_ff & ~`CFG_USED_MASK) == `WORD_RST);
  assign mot_take = word_take && bank_high && ((shift_ff & `MOTOR_ZERO_MASK) == `WORD_RST);

  // ************************************************************
  // configuration
  // ************************************************************
  // sense method and reference gain from the configuration word
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sense_method_select <= 1'b0;
      gain_select <= 1'b0;
    end else if (cfg_take) begin
      sense_method_select <= shift_ff[`CFG_SENSE_BIT];
      gain_select <= shift_ff[`CFG_GAIN_BIT];
    end
  end

  // ************************************************************
  // pending and applied motor settings
  // ************************************************************
  motor_word_s pending_ff;
  logic apply_ff;

  // currents held pending, applied two cycles after the latch
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pending_ff <= motor_word_s'(`WORD_RST);
      apply_ff <= 1'b0;
    end else begin
      apply_ff <= mot_take && !standby;
      if (mot_take) begin
        pending_ff <= motor_word_s'(shift_ff);
      end
    end
  end

  logic [2:0] torque_code_ff;

  // bridge settings move only on an applied command
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      torque_code_ff <= `RST_TORQUE;
      decay_a <= `RST_DECAY;
      polarity_a <= 1'b0;
      current_code_a <= `RST_CURRENT;
      decay_b <= `RST_DECAY;
      polarity_b <= 1'b0;
      current_code_b <= `RST_CURRENT;
    end else if (apply_ff) begin
      torque_code_ff <= pending_ff.torque_code;
      decay_a <= pending_ff.decay_a;
      polarity_a <= pending_ff.polarity_a;
      current_code_a <= pending_ff.current_a;
      decay_b <= pending_ff.decay_b;
      polarity_b <= pending_ff.polarity_b;
      current_code_b <= pending_ff.current_b;
    end
  end

  // one step per applied command
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      step_count <= `STEP_RST;
    end else if (apply_ff) begin
      step_count <= step_count + `STEP_ONE;
    end
  end

  // ************************************************************
  // torque and current limit
  // ************************************************************
  function automatic pct_t pct_of(input logic [2:0] code);
    pct_t p;
    p = `TQ_PCT_0;
    unique case (code)
      3'h0: p = `TQ_PCT_0;
      3'h1: p = `TQ_PCT_1;
      3'h2: p = `TQ_PCT_2;
      3'h3: p = `TQ_PCT_3;
      3'h4: p = `TQ_PCT_4;
      3'h5: p = `TQ_PCT_5;
      3'h6: p = `TQ_PCT_6;
      3'h7: p = `TQ_PCT_7;
    endcase
    return p;
  endfunction

  function automatic current_code_t scale(input current_code_t code, input pct_t pct);
    logic [16:0] prod;
    logic [16:0] quot;
    prod = {7'h00, code} * {10'h000, pct};
    quot = prod / `PCT_DIVISOR;
    return quot[9:0];
  endfunction

  // percent and full-scale fraction registered toward the DACs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      torque_percent <= `RST_PCT;
      current_limit_a <= `RST_CURRENT;
      current_limit_b <= `RST_CURRENT;
    end else begin
      torque_percent <= pct_of(torque_code_ff);
      current_limit_a <= scale(current_code_a, torque_percent);
      current_limit_b <= scale(current_code_b, torque_percent);
    end
  end

  // ************************************************************
  // drive state
  // ************************************************************
  drive_state_e state_ff;
  drive_state_e nxt_state;

  // configured, then driving after the first motor command
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (apply_ff) begin
          nxt_state = ST_DRIVE;
        end else if (cfg_take) begin
          nxt_state = ST_CONFIG;
        end
      end
      ST_CONFIG: begin
        if (apply_ff) begin
          nxt_state = ST_DRIVE;
        end
      end
      ST_DRIVE: begin
        if (standby) begin
          nxt_state = ST_CONFIG;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  // state register and output-stage enables
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= ST_IDLE;
      bridge_enable <= 1'b0;
      osc_enable <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      bridge_enable <= (nxt_state == ST_DRIVE) && !standby;
      osc_enable <= !standby;
    end
  end

  // ************************************************************
  // faults and flags
  // ************************************************************
  open_load_if ol_a();
  open_load_if ol_b();

  assign ol_a.charge = flt_ff[`IN_CHARGE_A];
  assign ol_a.threshold = flt_ff[`IN_THRESH_A];
  assign ol_b.charge = flt_ff[`IN_CHARGE_B];
  assign ol_b.threshold = flt_ff[`IN_THRESH_B];

  // both channels watched
  open_load_detect #(.WAIT_CYCLES(OPEN_WAIT_CYCLES)) u_open_a (
    .clk(clk),
    .rst(rst),
    .ch(ol_a)
  );
  open_load_detect #(.WAIT_CYCLES(OPEN_WAIT_CYCLES)) u_open_b (
    .clk(clk),
    .rst(rst),
    .ch(ol_b)
  );

  logic open_load_fault;
  logic thermal_latch_ff;
  logic overcur_latch_ff;

  assign open_load_fault = ol_a.open_load | ol_b.open_load;

  // sticky faults: standby clears, a new fault beats a supply return
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      thermal_latch_ff <= 1'b0;
      overcur_latch_ff <= 1'b0;
    end else if (standby) begin
      thermal_latch_ff <= 1'b0;
      overcur_latch_ff <= 1'b0;
    end else begin
      if (flt_ff[`IN_THERMAL]) begin
        thermal_latch_ff <= 1'b1;
      end else if (supply_rise) begin
        thermal_latch_ff <= 1'b0;
      end
      if (flt_ff[`IN_OVERCUR]) begin
        overcur_latch_ff <= 1'b1;
      end else if (supply_rise) begin
        overcur_latch_ff <= 1'b0;
      end
    end
  end

  // open-drain encoding; enable high pulls the pin low
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fault_flag0_o <= 1'b0;
      fault_flag1_o <= 1'b0;
      fault_flag0_oe <= 1'b0;
      fault_flag1_oe <= 1'b0;
    end else begin
      fault_flag0_o <= 1'b0;
      fault_flag1_o <= 1'b0;
      fault_flag0_oe <= !standby && (thermal_latch_ff || overcur_latch_ff);
      fault_flag1_oe <= !standby && (thermal_latch_ff || (!overcur_latch_ff && open_load_fault));
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  a_cfg_sense_apply: assert property (@(posedge clk) disable iff (rst)
    cfg_take |=> sense_method_select == $past(shift_ff[`CFG_SENSE_BIT]))
    else $error("sense select not taken from configuration word");
  a_latch_to_bridge: assert property (@(posedge clk) disable iff (rst)
    mot_take && !standby ##1 !standby |=> current_code_b == $past(pending_ff.current_b))
    else $error("current not applied two cycles after latch");
  a_current_held: assert property (@(posedge clk) disable iff (rst)
    !$past(apply_ff) |-> $stable(current_code_a) && $stable(polarity_a))
    else $error("bridge current changed without a latch");
  a_step_once: assert property (@(posedge clk) disable iff (rst)
    apply_ff |=> step_count == $past(step_count) + `STEP_ONE)
    else $error("step count did not advance by one");
  a_torque_map: assert property (@(posedge clk) disable iff (rst)
    torque_code_ff == 3'h6 |=> torque_percent == `TQ_PCT_6)
    else $error("torque code six not mapped to 25 percent");
  a_limit_scale: assert property (@(posedge clk) disable iff (rst)
    current_code_a == 10'h3ff && torque_percent == `TQ_PCT_4 |=> current_limit_a == 10'h1ff)
    else $error("current limit not scaled by torque");
  a_thermal_flags: assert property (@(posedge clk) disable iff (rst)
    thermal_latch_ff && !standby |=> fault_flag0_oe && fault_flag1_oe)
    else $error("thermal fault not shown on both flags");
  a_fault_sticky: assert property (@(posedge clk) disable iff (rst)
    overcur_latch_ff && !standby && !supply_rise |=> overcur_latch_ff)
    else $error("overcurrent latch dropped without release");
  a_standby_off: assert property (@(posedge clk) disable iff (rst)
    standby |=> !bridge_enable && !osc_enable && !fault_flag0_oe && !fault_flag1_oe)
    else $error("standby left outputs or flags active");
  a_serial_gate: assert property (@(posedge clk) disable iff (rst)
    !serial_on |=> count_ff == `BIT_COUNT_RST)
    else $error("serial bits counted with interface select low");

  c_cfg_taken: cover property (@(posedge clk) disable iff (rst) cfg_take);
  c_drive_on: cover property (@(posedge clk) disable iff (rst) $rose(bridge_enable));
  c_open_flag: cover property (@(posedge clk) disable iff (rst)
    $rose(fault_flag1_oe) && !fault_flag0_oe);
  c_thermal_flag: cover property (@(posedge clk) disable iff (rst) thermal_latch_ff);
endmodule // stepper_serial_top

//--- verif/host_model.sv
// host model that shifts serial command words into the stepper block
`timescale 1ns/10ps
module host_model (
  input wire logic clk,
  output logic serial_clk,
  output logic serial_data,
  output logic latch,
  output logic bank_sel
);
  initial begin
    {serial_clk, serial_data, latch, bank_sel} = 4'h0;
  end
  // wait n edges, then change pins just after the edge
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // n bits of w, bit 0 first, each serial clock level held 4 cycles; latch pulse if lt
  task automatic send(input logic bank, input logic [31:0] w, input int n, input logic lt);
    bank_sel = bank;
    for (int i = 0; i < n; i++) begin
      serial_data = w[i];
      hold(4);
      serial_clk = 1'b1;
      hold(4);
      serial_clk = 1'b0;
    end
    serial_data = ~serial_data; // data no longer valid
    hold(4);
    if (lt) begin
      latch = 1'b1;
      hold(12);
      latch = 1'b0;
      hold(6);
    end
  endtask
endmodule // host_model

//--- verif/testbench.sv
// self-checking bench for the serial stepper command block
`timescale 1ns/10ps
module testbench;
  import stepper_pkg::*;
  localparam int unsigned WAIT = 20;
  localparam logic [6:0] PCT [8] = '{7'h64, 7'h55, 7'h46, 7'h3c, 7'h32, 7'h28, 7'h19, 7'h0a};
  localparam logic [1:0] FS [4] = '{2'b11, 2'b01, 2'b00, 2'b10};
  logic clk, rst, if_sel, standby_n, supply, th, oc, sck, sda, lat, bank;
  logic [1:0] chg, thr, da, db;
  logic sense, gain, pa, pb, br, osc, f0o, f0e, f1o, f1e;
  logic [6:0] pct;
  logic [9:0] ca, cb, la, lb;
  logic [7:0] step;
  int num_errors = 0;
  int checks_done = 0;

  host_model u_host_model (.clk(clk), .serial_clk(sck), .serial_data(sda), .latch(lat),
    .bank_sel(bank));
  stepper_serial_top #(.OPEN_WAIT_CYCLES(WAIT)) u_stepper_serial_top (.clk(clk), .rst(rst),
    .if_sel(if_sel), .bank_sel(bank), .serial_clk(sck), .serial_data(sda), .latch(lat),
    .standby_n(standby_n), .motor_supply(supply), .thermal_shutdown_fault(th),
    .overcurrent_fault(oc), .charge_phase_a(chg[0]), .charge_phase_b(chg[1]),
    .current_threshold_reached_a(thr[0]), .current_threshold_reached_b(thr[1]),
    .sense_method_select(sense), .gain_select(gain), .torque_percent(pct), .decay_a(da),
    .polarity_a(pa), .current_code_a(ca), .current_limit_a(la), .decay_b(db),
    .polarity_b(pb), .current_code_b(cb), .current_limit_b(lb), .bridge_enable(br),
    .osc_enable(osc), .step_count(step), .fault_flag0_o(f0o), .fault_flag0_oe(f0e),
    .fault_flag1_o(f1o), .fault_flag1_oe(f1e));

  // compare one value and report a mismatch
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  // verdict and end of run
  task automatic complete_run;
    if (num_errors == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // motor word built from its fields
  function automatic logic [31:0] mw(logic [2:0] t, logic [1:0] a, logic [1:0] b, logic p,
    logic q, logic [9:0] x, logic [9:0] y);
    return {y, q, b, x, p, a, 1'b0, t, 2'b00};
  endfunction

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // watchdog well beyond the expected run length
  initial begin
    #300000;
    num_errors++;
    complete_run();
  end

  initial begin
    {rst, if_sel, standby_n, supply, th, oc} = 6'h3c;
    {chg, thr} = 4'h0;
    wt(8);
    rst = 1'b0;
    wt(8);
    chk("pct", 7'h64, pct);
    chk("step", 8'h00, step);
    chk("br_osc", 2'b01, {br, osc});
    chk("pins", 4'h0, {f0o, f0e, f1o, f1e});
    // configuration words, one with a must-be-zero bit set
    u_host_model.send(1'b0, 32'h0000_3000, 32, 1'b1);
    chk("cfg", 2'b11, {sense, gain});
    u_host_model.send(1'b0, 32'h0000_1001, 32, 1'b1);
    chk("cfg", 2'b11, {sense, gain});
    u_host_model.send(1'b0, 32'h0000_1000, 32, 1'b1);
    chk("cfg", 2'b10, {sense, gain});
    u_host_model.send(1'b0, 32'h0000_2000, 32, 1'b1);
    chk("cfg", 2'b01, {sense, gain});
    // serial interface deselected
    if_sel = 1'b0;
    u_host_model.send(1'b1, mw(3'h0, 2'h0, 2'h0, 1, 1, 10'h3ff, 10'h3ff), 32, 1'b1);
    chk("step", 8'h00, step);
    chk("br", 1'b0, br);
    if_sel = 1'b1;
    // full-step sequence
    for (int i = 0; i < 4; i++) begin
      u_host_model.send(1'b1, mw(3'h0, 2'h0, 2'h0, FS[i][1], FS[i][0], 10'h3ff, 10'h3ff),
        32, 1'b1);
      chk("pol", FS[i], {pa, pb});
      chk("step", i + 1, step);
      chk("br", 1'b1, br);
      chk("code", {10'h3ff, 10'h3ff}, {ca, cb});
    end
    // every torque and decay code
    for (int t = 0; t < 8; t++) begin
      u_host_model.send(1'b1, mw(t, t, ~t, 1, 0, 10'h3ff, 10'h2aa), 32, 1'b1);
      chk("pct", PCT[t], pct);
      chk("lim_a", (1023 * PCT[t]) / 100, la);
      chk("lim_b", (682 * PCT[t]) / 100, lb);
      chk("decay", {t[1:0], ~t[1:0]}, {da, db});
      chk("code_b", 10'h2aa, cb);
    end
    // refused words: D5 set, then a short word
    u_host_model.send(1'b1, mw(3'h0, 2'h0, 2'h0, 0, 0, 10'h1, 10'h1) | 32'h20, 32, 1'b1);
    chk("step", 8'h0c, step);
    u_host_model.send(1'b1, mw(3'h0, 2'h0, 2'h0, 0, 0, 10'h1, 10'h1), 16, 1'b1);
    chk("step", 8'h0c, step);
    // pending word applied only by a later latch
    u_host_model.send(1'b1, mw(3'h0, 2'h0, 2'h0, 0, 0, 10'h155, 10'h0ab), 32, 1'b0);
    chk("code_a", 10'h3ff, ca);
    u_host_model.send(1'b1, 32'h0, 0, 1'b1);
    chk("code", {10'h155, 10'h0ab, 8'h0d}, {ca, cb, step});
    // overcurrent latches until supply returns
    oc = 1'b1;
    wt(8);
    chk("flags", 2'b10, {f0e, f1e});
    oc = 1'b0;
    wt(8);
    chk("flags", 2'b10, {f0e, f1e});
    supply = 1'b0;
    wt(6);
    supply = 1'b1;
    wt(8);
    chk("flags", 2'b00, {f0e, f1e});
    // thermal latches until standby
    th = 1'b1;
    wt(8);
    th = 1'b0;
    wt(8);
    chk("flags", 2'b11, {f0e, f1e});
    standby_n = 1'b0;
    wt(8);
    chk("stby", 4'h0, {f0e, f1e, br, osc});
    standby_n = 1'b1;
    wt(8);
    chk("stby", 4'h1, {f0e, f1e, br, osc});
    u_host_model.send(1'b1, mw(3'h0, 2'h0, 2'h0, 1, 1, 10'h3ff, 10'h3ff), 32, 1'b1);
    chk("br", 1'b1, br);
    // open load on each channel
    for (int c = 0; c < 2; c++) begin
      chg[c] = 1'b1;
      wt(10);
      chk("open", 1'b0, f1e);
      wt(WAIT + 6);
      chk("open", 3'b011, {f0e, f1e, br});
      wt(4);
      chk("open", 1'b1, f1e);
      thr[c] = 1'b1;
      wt(6);
      chk("open", 1'b1, f1e);
      chg[c] = 1'b0;
      wt(8);
      thr[c] = 1'b0;
      chk("open", 1'b0, f1e);
    end
    complete_run();
  end
endmodule // testbench
